// ### common/cnc_pkg.sv
// Purpose: Shared constants and types for the network configuration and I/O table block.
// Assumes: Single 10 MHz clock, synchronous active-low reset.
// Notes: Register offsets are byte addresses on the plain register port.
package cnc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int ADDR_LIST_MAX = 10;
    localparam logic [7:0] ADDR_MAX_VALID = 8'hfd;
    localparam int TABLE_BYTES = 2048;
    localparam int MAP_MAX = 200;
    localparam int PGN_IN_MAX = 120;
    localparam int PGN_OUT_MAX = 100;
    localparam int OFFLINE_MIN_MS = 1000;
    localparam int OFFLINE_MAX_MS = 60000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    // Register byte addresses.
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00c;
    localparam logic [11:0] REG_NAME_LO = 12'h010;
    localparam logic [11:0] REG_NAME_HI = 12'h014;
    localparam logic [11:0] REG_OFFLINE_MS = 12'h018;
    localparam logic [11:0] REG_LIST_CNT = 12'h01c;
    localparam logic [11:0] REG_COUNTS = 12'h020;
    localparam logic [11:0] REG_ADDR_BASE = 12'h040;
    localparam logic [11:0] REG_IN_BASE = 12'h800;
    // Control bits.
    localparam int CTRL_BUSOFF_RST = 0;
    localparam int CTRL_SWAP = 1;
    localparam int CTRL_OFFLINE_EN = 2;
    localparam int CTRL_BAUD500 = 3;
    // Interrupt bits.
    localparam int IRQ_CLAIMED = 0;
    localparam int IRQ_BUSOFF = 1;
    localparam int IRQ_OFFLINE = 2;
    localparam int IRQ_NOADDR = 3;
    localparam int IRQ_W = 4;
    localparam logic [7:0] ADDR_NULL = 8'hfe;
    typedef enum logic [2:0] {CNC_INIT, CNC_CLAIM, CNC_ONLINE, CNC_BUSOFF,
                              CNC_OFFLINE, CNC_NOADDR} cnc_state_t;
endpackage

// ### rtl/cnc_table_ram.sv
// Purpose: Byte-wide dual-port table memory with optional 16-bit byte swap on the read side.
// Assumes: Synchronous write and registered read.
// Notes: Swap flips address bit 0, exchanging the bytes of every 16-bit word.
`timescale 1ns/10ps
`default_nettype none
module cnc_table_ram
    import cnc_pkg::*;
#(
    parameter int DEPTH = TABLE_BYTES,
    parameter int AW = $clog2(TABLE_BYTES)
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic swapEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] rdIdx;

    assign rdIdx = {rdAddr[AW-1:1], rdAddr[0] ^ swapEn};

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdIdx];
    end
endmodule
`default_nettype wire

// ### rtl/cnc_gateway.sv
// Purpose: Network-side configuration, address claim sequencing and I/O tables.
// Assumes: CAN controller and frame engine sit outside; they report claim and bus events.
// Notes: Initialization runs from reset to the first control write; configuration is latched then.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cnc_gateway
    import cnc_pkg::*;
#(
    parameter int AW = $clog2(TABLE_BYTES),
    parameter int MS_CYCLES = CYC_PER_MS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic irq,
    input wire logic claimOk,
    input wire logic claimLost,
    input wire logic busOff,
    input wire logic rxActivity,
    input wire logic rxWr,
    input wire logic [AW-1:0] rxAddr,
    input wire logic [7:0] rxData,
    input wire logic [AW-1:0] txAddr,
    output logic [7:0] txData,
    output logic claimReq,
    output logic [7:0] claimAddr,
    output logic [63:0] claimName,
    output logic canResetReq,
    output logic baud500,
    output logic txAllowed
);
    typedef struct packed {
        logic [3:0] ctrl;
        logic [63:0] name;
        logic [15:0] offlineMs;
        logic [3:0] listCnt;
        logic [ADDR_LIST_MAX-1:0][7:0] addrList;
        logic [7:0] mapCnt;
        logic [6:0] pgnIn;
        logic [6:0] pgnOut;
        logic [3:0] cfgCtrl;
        logic [15:0] cfgOffMs;
        logic [3:0] cfgCnt;
        logic latched;
        cnc_state_t state;
        logic [3:0] idx;
        logic [7:0] curAddr;
        logic [15:0] msCnt;
        logic [15:0] idleMs;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        logic rdIsTable;
        logic [31:0] rdData;
        logic resetPulse;
    } cnc_regs_t;

    cnc_regs_t s_r;
    cnc_regs_t s_nxt;
    logic [7:0] inRd;
    logic [7:0] outRd;
    logic outWr;
    logic [AW-1:0] hostIdx;
    logic [IRQ_W-1:0] evt;

    function automatic logic validAddr(input logic [7:0] a);
        return a <= ADDR_MAX_VALID;
    endfunction

    assign hostIdx = regAddr[AW-1:0];
    assign outWr = regWr && (regAddr >= REG_IN_BASE) && regAddr[AW];

    cnc_table_ram #(.AW(AW)) uIn (
        .clk(clk), .wrEn(rxWr), .wrAddr(rxAddr), .wrData(rxData),
        .swapEn(s_r.cfgCtrl[CTRL_SWAP]), .rdAddr(hostIdx), .rdData(inRd)
    );
    cnc_table_ram #(.AW(AW)) uOut (
        .clk(clk), .wrEn(outWr), .wrAddr(hostIdx), .wrData(regWrData[7:0]),
        .swapEn(s_r.cfgCtrl[CTRL_SWAP]), .rdAddr(txAddr), .rdData(outRd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        s_nxt.resetPulse = 1'b0;
        evt = '0;
        s_nxt.rdIsTable = 1'b0;
        // Register writes.
        if (regWr) begin
            case (regAddr)
                REG_CTRL: s_nxt.ctrl = regWrData[3:0];
                REG_NAME_LO: s_nxt.name[31:0] = regWrData;
                REG_NAME_HI: s_nxt.name[63:32] = regWrData;
                REG_OFFLINE_MS: begin
                    if (regWrData[15:0] >= 16'(OFFLINE_MIN_MS) &&
                            regWrData[15:0] <= 16'(OFFLINE_MAX_MS)) begin
                        s_nxt.offlineMs = regWrData[15:0];
                    end
                end
                REG_LIST_CNT: begin
                    if (regWrData[3:0] <= 4'(ADDR_LIST_MAX)) begin
                        s_nxt.listCnt = regWrData[3:0];
                    end
                end
                REG_COUNTS: begin
                    if (regWrData[7:0] <= 8'(MAP_MAX)) s_nxt.mapCnt = regWrData[7:0];
                    if (regWrData[14:8] <= 7'(PGN_IN_MAX)) s_nxt.pgnIn = regWrData[14:8];
                    if (regWrData[22:16] <= 7'(PGN_OUT_MAX)) s_nxt.pgnOut = regWrData[22:16];
                end
                REG_IRQ_MASK: s_nxt.irqMask = regWrData[IRQ_W-1:0];
                default: begin
                    for (int i = 0; i < ADDR_LIST_MAX; i++) begin
                        if (regAddr == REG_ADDR_BASE + 12'(4 * i) &&
                                validAddr(regWrData[7:0])) begin
                            s_nxt.addrList[i] = regWrData[7:0];
                        end
                    end
                end
            endcase
        end
        // Sequencer.
        case (s_r.state)
            CNC_INIT: begin
                s_nxt.cfgCtrl = s_r.ctrl;
                s_nxt.cfgOffMs = s_r.offlineMs;
                s_nxt.cfgCnt = s_r.listCnt;
                s_nxt.idx = '0;
                // The first control write ends initialization; the next cycle latches it.
                if (regWr && regAddr == REG_CTRL) begin
                    s_nxt.latched = 1'b1;
                end
                if (s_r.latched) begin
                    if (s_r.cfgCnt == '0) begin
                        s_nxt.state = CNC_NOADDR;
                        evt[IRQ_NOADDR] = 1'b1;
                    end else begin
                        s_nxt.state = CNC_CLAIM;
                        s_nxt.curAddr = s_r.addrList[0];
                    end
                end
            end
            CNC_CLAIM: begin
                if (busOff) begin
                    s_nxt.state = CNC_BUSOFF;
                end else if (claimOk) begin
                    s_nxt.state = CNC_ONLINE;
                    evt[IRQ_CLAIMED] = 1'b1;
                end else if (claimLost) begin
                    if (s_r.idx + 4'h1 >= s_r.cfgCnt) begin
                        s_nxt.state = CNC_NOADDR;
                        s_nxt.curAddr = ADDR_NULL;
                        evt[IRQ_NOADDR] = 1'b1;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                        s_nxt.curAddr = s_r.addrList[s_r.idx + 4'h1];
                    end
                end
            end
            CNC_ONLINE: begin
                if (busOff) begin
                    s_nxt.state = CNC_BUSOFF;
                end else if (claimLost) begin
                    s_nxt.state = CNC_CLAIM;
                end
            end
            CNC_BUSOFF: begin
                evt[IRQ_BUSOFF] = 1'b1;
                if (s_r.cfgCtrl[CTRL_BUSOFF_RST]) begin
                    s_nxt.resetPulse = 1'b1;
                    s_nxt.idx = '0;
                    s_nxt.curAddr = s_r.addrList[0];
                    s_nxt.state = CNC_CLAIM;
                end else begin
                    s_nxt.state = CNC_OFFLINE;
                end
            end
            CNC_OFFLINE: s_nxt.state = CNC_OFFLINE;
            CNC_NOADDR: s_nxt.state = CNC_NOADDR;
            default: s_nxt.state = CNC_INIT;
        endcase
        // Offline detection by silence timer.
        if (rxActivity || !s_r.cfgCtrl[CTRL_OFFLINE_EN]) begin
            s_nxt.msCnt = '0;
            s_nxt.idleMs = '0;
        end else if (s_r.msCnt == 16'(MS_CYCLES - 1)) begin
            s_nxt.msCnt = '0;
            if (s_r.idleMs != s_r.cfgOffMs) begin
                s_nxt.idleMs = s_r.idleMs + 16'h1;
                if (s_r.idleMs + 16'h1 == s_r.cfgOffMs) evt[IRQ_OFFLINE] = 1'b1;
            end
        end else begin
            s_nxt.msCnt = s_r.msCnt + 16'h1;
        end
        // Sticky status: set wins over write-one-to-clear.
        if (regWr && regAddr == REG_IRQ_STAT) begin
            s_nxt.irqStat = s_r.irqStat & ~regWrData[IRQ_W-1:0];
        end
        s_nxt.irqStat = s_nxt.irqStat | evt;
        // Register reads, data next cycle.
        s_nxt.rdData = '0;
        if (regRd) begin
            if (regAddr >= REG_IN_BASE) begin
                // The table window reads the Input table and writes the Output table.
                s_nxt.rdIsTable = 1'b1;
            end else begin
                case (regAddr)
                    REG_CTRL: s_nxt.rdData = {28'h0, s_r.ctrl};
                    REG_STATUS: s_nxt.rdData = {16'h0, s_r.idx, 1'b0, 3'(s_r.state), s_r.curAddr};
                    REG_IRQ_STAT: s_nxt.rdData = {28'h0, s_r.irqStat};
                    REG_IRQ_MASK: s_nxt.rdData = {28'h0, s_r.irqMask};
                    REG_NAME_LO: s_nxt.rdData = s_r.name[31:0];
                    REG_NAME_HI: s_nxt.rdData = s_r.name[63:32];
                    REG_OFFLINE_MS: s_nxt.rdData = {16'h0, s_r.offlineMs};
                    REG_LIST_CNT: s_nxt.rdData = {28'h0, s_r.listCnt};
                    REG_COUNTS: s_nxt.rdData = {9'h0, s_r.pgnOut, 1'b0, s_r.pgnIn, s_r.mapCnt};
                    default: begin
                        for (int i = 0; i < ADDR_LIST_MAX; i++) begin
                            if (regAddr == REG_ADDR_BASE + 12'(4 * i)) begin
                                s_nxt.rdData = {24'h0, s_r.addrList[i]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.state <= CNC_INIT;
            s_r.offlineMs <= 16'(OFFLINE_MIN_MS);
            s_r.cfgOffMs <= 16'(OFFLINE_MIN_MS);
            s_r.curAddr <= ADDR_NULL;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign regRdData = s_r.rdIsTable ? {24'h0, inRd} : s_r.rdData;
    assign irq = |(s_r.irqStat & s_r.irqMask);
    assign txData = outRd;
    assign claimReq = (s_r.state == CNC_CLAIM);
    assign claimAddr = s_r.curAddr;
    assign claimName = s_r.name;
    assign canResetReq = s_r.resetPulse;
    assign baud500 = s_r.cfgCtrl[CTRL_BAUD500];
    assign txAllowed = (s_r.state == CNC_ONLINE);

    ////////////////////////////////////////////////////////////////////////////////
    AST_FALLBACK: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state == CNC_CLAIM && claimLost && !busOff && !claimOk &&
        s_r.idx + 4'h1 < s_r.cfgCnt |=> claimAddr == s_r.addrList[$past(s_r.idx) + 4'h1])
        else $error("Claim did not move to next address.");
    AST_NOADDR: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state == CNC_NOADDR |-> !txAllowed && claimAddr == ADDR_NULL ##1 s_r.state == CNC_NOADDR)
        else $error("Transmission allowed without an address.");
    AST_RECOVER: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state == CNC_BUSOFF && s_r.cfgCtrl[CTRL_BUSOFF_RST] |=> canResetReq ##0 claimReq)
        else $error("Bus-off recovery did not reset and reclaim.");
    AST_STAY_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state == CNC_BUSOFF && !s_r.cfgCtrl[CTRL_BUSOFF_RST] |=> (!txAllowed && !canResetReq)[*8])
        else $error("Device left offline state.");
    AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state != CNC_INIT && $past(s_r.state) != CNC_INIT |->
        $stable(baud500) && $stable(s_r.cfgCtrl) && $stable(s_r.cfgCnt))
        else $error("Configuration changed after initialization.");
    AST_LIST_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.listCnt <= 4'(ADDR_LIST_MAX) && (validAddr(claimAddr) || claimAddr == ADDR_NULL))
        else $error("Address list out of range.");
    AST_NAME: assert property (@(posedge clk) disable iff (!rst_n)
        claimReq |-> claimName == s_r.name)
        else $error("Claim NAME mismatch.");
    AST_LIMITS: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.mapCnt <= 8'(MAP_MAX) && s_r.pgnIn <= 7'(PGN_IN_MAX) && s_r.pgnOut <= 7'(PGN_OUT_MAX))
        else $error("Mapping limits exceeded.");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.state == CNC_CLAIM && claimOk && !busOff |=> s_r.irqStat[IRQ_CLAIMED])
        else $error("Claim event not recorded.");
    COV_CLAIM: cover property (@(posedge clk) disable iff (!rst_n) s_r.state == CNC_ONLINE);
    COV_FALL: cover property (@(posedge clk) disable iff (!rst_n) claimReq && claimLost ##1 claimReq);
    COV_BUSOFF: cover property (@(posedge clk) disable iff (!rst_n) canResetReq);
    COV_OFFLINE: cover property (@(posedge clk) disable iff (!rst_n) s_r.irqStat[IRQ_OFFLINE]);
endmodule
`default_nettype wire

// ### verification/cnc_engine_model.sv
// Purpose: Behavioural model of the CAN frame engine that faces the gateway block.
// Assumes: One clock; every request changes just after a rising edge.
// Notes: Released data lines show the inverse of their last value.
`timescale 1ns/10ps
`default_nettype none
module cnc_engine_model
    import cnc_pkg::*;
#(
    parameter int AW = $clog2(TABLE_BYTES)
) (
    input wire logic clk,
    output logic claimOk,
    output logic claimLost,
    output logic busOff,
    output logic rxActivity,
    output logic rxWr,
    output logic [AW-1:0] rxAddr,
    output logic [7:0] rxData,
    output logic [AW-1:0] txAddr,
    input wire logic [7:0] txData
);
    initial begin
        claimOk = 1'b0;
        claimLost = 1'b0;
        busOff = 1'b0;
        rxActivity = 1'b0;
        rxWr = 1'b0;
        rxAddr = '0;
        rxData = 8'h00;
        txAddr = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A received byte is written into the input table in one strobed cycle.
    task automatic put_rx(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge clk);
        rxWr <= 1'b1;
        rxAddr <= a;
        rxData <= d;
        rxActivity <= 1'b1;
        @(posedge clk);
        rxWr <= 1'b0;
        rxActivity <= 1'b0;
        rxAddr <= ~a;
        rxData <= ~d;
    endtask

    // The frame builder fetches an output byte; the data stands one cycle later.
    task automatic get_tx(input logic [AW-1:0] a, output logic [7:0] d);
        @(posedge clk);
        txAddr <= a;
        @(posedge clk);
        #1;
        d = txData;
    endtask

    // Single-cycle engine events: 0 claim won, 1 claim lost, 2 bus-off.
    task automatic pulse_event(input int kind);
        @(posedge clk);
        claimOk <= (kind == 0);
        claimLost <= (kind == 1);
        busOff <= (kind == 2);
        @(posedge clk);
        claimOk <= 1'b0;
        claimLost <= 1'b0;
        busOff <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the network configuration and table block.
// Assumes: Initialization lasts until the first control write, which latches the configuration.
// Notes: Output table writes use byte address regAddr[10:0] when bit 11 is set.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cnc_pkg::*;
    logic clk, rst_n, regWr, regRd, irq, claimReq, canResetReq, baud500, txAllowed;
    logic [11:0] regAddr;
    logic [31:0] regWrData, regRdData;
    logic claimOk, claimLost, busOff, rxActivity, rxWr;
    logic [10:0] rxAddr, txAddr;
    logic [7:0] rxData, txData, claimAddr, b;
    logic [63:0] claimName;
    logic [31:0] d;
    logic sawCanReset;
    int miscompares, checksDone;

    cnc_gateway #(.MS_CYCLES(2)) DUT (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .irq(irq), .claimOk(claimOk), .claimLost(claimLost), .busOff(busOff),
        .rxActivity(rxActivity), .rxWr(rxWr), .rxAddr(rxAddr), .rxData(rxData),
        .txAddr(txAddr), .txData(txData), .claimReq(claimReq), .claimAddr(claimAddr),
        .claimName(claimName), .canResetReq(canResetReq), .baud500(baud500),
        .txAllowed(txAllowed));
    cnc_engine_model partner (.clk(clk), .claimOk(claimOk), .claimLost(claimLost),
        .busOff(busOff), .rxActivity(rxActivity), .rxWr(rxWr), .rxAddr(rxAddr),
        .rxData(rxData), .txAddr(txAddr), .txData(txData));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            sawCanReset <= 1'b0;
        end else if (canResetReq) begin
            sawCanReset <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        v = regRdData;
    endtask

    // Writes a value, reads it back and compares with what should remain.
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] v, input logic [31:0] e);
        reg_wr(a, v);
        reg_rd(a, d);
        check(d, e, "register readback");
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(5000 * 100);
        miscompares++;
        close_out();
    end

    initial begin
        miscompares = 0;
        checksDone = 0;
        rst_n = 1'b0;
        regAddr = 12'h000;
        regWrData = 32'h0000_0000;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(claimAddr, 8'hfe, "no address held");
        check(txAllowed, 1'b0, "transmit stopped");
        check(claimReq, 1'b0, "no claim running");
        check(baud500, 1'b0, "default bit rate");
        check(irq, 1'b0, "interrupt idle");
        reg_rd(REG_OFFLINE_MS, d);
        check(d, 32'h0000_03e8, "offline time default");
        $display("test reset done");

        wr_chk(REG_OFFLINE_MS, 32'd999, 32'd1000);
        wr_chk(REG_OFFLINE_MS, 32'd60000, 32'd60000);
        wr_chk(REG_OFFLINE_MS, 32'd60001, 32'd60000);
        wr_chk(REG_OFFLINE_MS, 32'd1000, 32'd1000);
        wr_chk(REG_ADDR_BASE, 32'h0000_00fd, 32'h0000_00fd);
        wr_chk(REG_ADDR_BASE, 32'h0000_00fe, 32'h0000_00fd);
        wr_chk(REG_ADDR_BASE + 12'h004, 32'h0000_0022, 32'h0000_0022);
        wr_chk(REG_ADDR_BASE + 12'h024, 32'h0000_0000, 32'h0000_0000);
        wr_chk(REG_LIST_CNT, 32'h0000_000a, 32'h0000_000a);
        wr_chk(REG_LIST_CNT, 32'h0000_000b, 32'h0000_000a);
        wr_chk(REG_LIST_CNT, 32'h0000_0002, 32'h0000_0002);
        wr_chk(REG_NAME_LO, 32'h89ab_cdef, 32'h89ab_cdef);
        wr_chk(REG_NAME_HI, 32'h0123_4567, 32'h0123_4567);
        wr_chk(REG_COUNTS, 32'h0064_78c8, 32'h0064_78c8);
        wr_chk(REG_COUNTS, 32'h0064_78c9, 32'h0064_78c8);
        wr_chk(REG_COUNTS, 32'h0064_79c8, 32'h0064_78c8);
        wr_chk(REG_COUNTS, 32'h0065_78c8, 32'h0064_78c8);
        wr_chk(12'h100, 32'h0000_0005, 32'h0000_0000);
        reg_wr(REG_CTRL, 32'h0000_000f);
        @(posedge clk);
        #1;
        check(claimReq, 1'b1, "first claim running");
        check(claimAddr, 8'hfd, "first listed address");
        check(claimName, 64'h0123_4567_89ab_cdef, "claim NAME");
        check(baud500, 1'b1, "fast bit rate");
        reg_wr(REG_CTRL, 32'h0000_0000);
        @(posedge clk);
        #1;
        check(baud500, 1'b1, "config held until reset");
        $display("test config done");

        partner.pulse_event(1);
        #1;
        check(claimAddr, 8'h22, "fallback address");
        partner.pulse_event(0);
        #1;
        check(txAllowed, 1'b1, "online after claim");
        partner.put_rx(11'h000, 8'h11);
        partner.put_rx(11'h001, 8'h22);
        partner.put_rx(11'h7fe, 8'h5a);
        repeat (1990) @(posedge clk);
        reg_rd(REG_IRQ_STAT, d);
        check(d, 32'h0000_0001, "no offline flag yet");
        repeat (10) @(posedge clk);
        reg_rd(REG_IRQ_STAT, d);
        check(d, 32'h0000_0005, "offline flag");
        reg_rd(REG_IN_BASE, d);
        check(d, 32'h0000_0022, "input byte 0 swapped");
        reg_rd(REG_IN_BASE + 12'h001, d);
        check(d, 32'h0000_0011, "input byte 1 swapped");
        reg_rd(12'hfff, d);
        check(d, 32'h0000_005a, "input last byte");
        reg_wr(12'hc05, 32'h0000_003c);
        reg_wr(12'hfff, 32'h0000_00a5);
        partner.get_tx(11'h404, b);
        check(b, 8'h3c, "output byte to network");
        partner.get_tx(11'h7fe, b);
        check(b, 8'ha5, "output last byte");
        $display("test tables done");

        partner.pulse_event(2);
        @(posedge clk);
        #1;
        check(canResetReq, 1'b1, "controller reset pulse");
        check(claimAddr, 8'hfd, "reclaim from first address");
        reg_rd(REG_IRQ_STAT, d);
        check(d, 32'h0000_0007, "bus-off flag");
        partner.pulse_event(1);
        partner.pulse_event(1);
        #1;
        check(claimAddr, 8'hfe, "list exhausted");
        check(claimReq, 1'b0, "claiming stopped");
        reg_wr(REG_IRQ_MASK, 32'h0000_0008);
        @(posedge clk);
        #1;
        check(irq, 1'b1, "no-address interrupt");
        reg_wr(REG_IRQ_STAT, 32'h0000_0008);
        @(posedge clk);
        #1;
        check(irq, 1'b0, "interrupt cleared");
        partner.pulse_event(0);
        #1;
        check(txAllowed, 1'b0, "still silent");
        $display("test events done");

        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(claimAddr, 8'hfe, "address cleared by reset");
        check(baud500, 1'b0, "bit rate back to default");
        check(irq, 1'b0, "interrupt cleared by reset");
        reg_wr(REG_ADDR_BASE, 32'h0000_0030);
        reg_wr(REG_LIST_CNT, 32'h0000_0001);
        reg_wr(REG_CTRL, 32'h0000_0000);
        @(posedge clk);
        #1;
        check(claimAddr, 8'h30, "new list after power cycle");
        reg_rd(REG_IN_BASE, d);
        check(d, 32'h0000_0011, "input byte 0 unswapped");
        partner.pulse_event(0);
        partner.pulse_event(2);
        partner.pulse_event(0);
        repeat (4) @(posedge clk);
        #1;
        check(txAllowed, 1'b0, "offline after bus-off");
        check(sawCanReset, 1'b0, "no recovery when disabled");
        reg_rd(REG_STATUS, d);
        check(d, 32'h0000_0430, "offline state held");
        $display("test power cycle done");
        close_out();
    end
endmodule
`default_nettype wire
